// *** rtl/exc_pkg.sv ***
// Constants, types and decode functions for the event priority unit
package exc_pkg;

	localparam int ADDR_W = 32;
	localparam int PRIO_W = 5;
	localparam int NUM_SLOTS = 32;
	localparam int AUTOVEC_W = 14;
	localparam int DIV_W = 4;

	// Start of internal flash, first fetch after reset
	localparam logic [31:0] RESET_ADDR = 32'h8000_0000;

	// Clock source codes, and values at start-up
	localparam logic [1:0] CLK_SRC_RC = 2'h0;
	localparam logic [1:0] CLK_SRC_RST = CLK_SRC_RC;
	localparam logic PLL_EN_RST = 1'b0;
	localparam logic [3:0] CLK_DIV_RST = 4'h0;

	// Priority numbers of event slots
	localparam logic [4:0] PRIO_DEBUG_STOP = 5'h02;
	localparam logic [4:0] PRIO_UNRECOV = 5'h03;
	localparam logic [4:0] PRIO_MULTI_HIT = 5'h04;
	localparam logic [4:0] PRIO_BUS_DATA = 5'h05;
	localparam logic [4:0] PRIO_BUS_INSTR = 5'h06;
	localparam logic [4:0] PRIO_NMI = 5'h07;
	localparam logic [4:0] PRIO_IRQ3 = 5'h08;
	localparam logic [4:0] PRIO_IRQ0 = 5'h0b;
	localparam logic [4:0] PRIO_INSTR_ADDR = 5'h0c;
	localparam logic [4:0] PRIO_ITRANS_MISS = 5'h0d;
	localparam logic [4:0] PRIO_ITRANS_PROT = 5'h0e;
	localparam logic [4:0] PRIO_BREAKPOINT = 5'h0f;
	localparam logic [4:0] PRIO_ILLEGAL = 5'h10;
	localparam logic [4:0] PRIO_UNIMPL = 5'h11;
	localparam logic [4:0] PRIO_PRIV = 5'h12;
	localparam logic [4:0] PRIO_FLOAT = 5'h13;
	localparam logic [4:0] PRIO_COPROC = 5'h14;
	localparam logic [4:0] PRIO_SVC = 5'h15;
	localparam logic [4:0] PRIO_DADDR_RD = 5'h16;
	localparam logic [4:0] PRIO_DADDR_WR = 5'h17;
	localparam logic [4:0] PRIO_DTRANS_MISS_RD = 5'h18;
	localparam logic [4:0] PRIO_DTRANS_MISS_WR = 5'h19;
	localparam logic [4:0] PRIO_DTRANS_PROT_RD = 5'h1a;
	localparam logic [4:0] PRIO_DTRANS_PROT_WR = 5'h1b;
	localparam logic [4:0] PRIO_DTRANS_MOD = 5'h1c;
	localparam logic [4:0] PRIO_NONE = 5'h1f;

	// Slots that can ever be raised: 2..28 without the two unused ones
	localparam logic [31:0] SLOT_VALID_MASK = 32'h0ff7_fffc;

	// Handler offsets from the vector base
	localparam logic [31:0] OFS_UNRECOV = 32'h0000_0000;
	localparam logic [31:0] OFS_MULTI_HIT = 32'h0000_0004;
	localparam logic [31:0] OFS_BUS_DATA = 32'h0000_0008;
	localparam logic [31:0] OFS_BUS_INSTR = 32'h0000_000c;
	localparam logic [31:0] OFS_NMI = 32'h0000_0010;
	localparam logic [31:0] OFS_INSTR_ADDR = 32'h0000_0014;
	localparam logic [31:0] OFS_ITRANS_PROT = 32'h0000_0018;
	localparam logic [31:0] OFS_BREAKPOINT = 32'h0000_001c;
	localparam logic [31:0] OFS_ILLEGAL = 32'h0000_0020;
	localparam logic [31:0] OFS_UNIMPL = 32'h0000_0024;
	localparam logic [31:0] OFS_PRIV = 32'h0000_0028;
	localparam logic [31:0] OFS_FLOAT = 32'h0000_002c;
	localparam logic [31:0] OFS_COPROC = 32'h0000_0030;
	localparam logic [31:0] OFS_DADDR_RD = 32'h0000_0034;
	localparam logic [31:0] OFS_DADDR_WR = 32'h0000_0038;
	localparam logic [31:0] OFS_DTRANS_PROT_RD = 32'h0000_003c;
	localparam logic [31:0] OFS_DTRANS_PROT_WR = 32'h0000_0040;
	localparam logic [31:0] OFS_DTRANS_MOD = 32'h0000_0044;
	localparam logic [31:0] OFS_ITRANS_MISS = 32'h0000_0050;
	localparam logic [31:0] OFS_DTRANS_MISS_RD = 32'h0000_0060;
	localparam logic [31:0] OFS_DTRANS_MISS_WR = 32'h0000_0070;
	localparam logic [31:0] OFS_SVC = 32'h0000_0100;

	// Increment applied to a supervisor call's own address
	localparam logic [31:0] SVC_RET_INC = 32'h0000_0002;

	// Where a handler address and a return address come from
	typedef enum logic [1:0] {
		VEC_FIXED = 2'h0,
		VEC_DEBUG = 2'h1,
		VEC_AUTO = 2'h2
	} vec_kind_type;

	typedef enum logic [1:0] {
		RET_OFFEND = 2'h0,
		RET_NONCOMPLETE = 2'h1,
		RET_SVC = 2'h2
	} ret_kind_type;

	// Fixed handler offset for a slot
	function automatic logic [31:0] handler_offset(input logic [4:0] p);
		case (p)
			PRIO_UNRECOV: handler_offset = OFS_UNRECOV;
			PRIO_MULTI_HIT: handler_offset = OFS_MULTI_HIT;
			PRIO_BUS_DATA: handler_offset = OFS_BUS_DATA;
			PRIO_BUS_INSTR: handler_offset = OFS_BUS_INSTR;
			PRIO_NMI: handler_offset = OFS_NMI;
			PRIO_INSTR_ADDR: handler_offset = OFS_INSTR_ADDR;
			PRIO_ITRANS_MISS: handler_offset = OFS_ITRANS_MISS;
			PRIO_ITRANS_PROT: handler_offset = OFS_ITRANS_PROT;
			PRIO_BREAKPOINT: handler_offset = OFS_BREAKPOINT;
			PRIO_ILLEGAL: handler_offset = OFS_ILLEGAL;
			PRIO_UNIMPL: handler_offset = OFS_UNIMPL;
			PRIO_PRIV: handler_offset = OFS_PRIV;
			PRIO_FLOAT: handler_offset = OFS_FLOAT;
			PRIO_COPROC: handler_offset = OFS_COPROC;
			PRIO_SVC: handler_offset = OFS_SVC;
			PRIO_DADDR_RD: handler_offset = OFS_DADDR_RD;
			PRIO_DADDR_WR: handler_offset = OFS_DADDR_WR;
			PRIO_DTRANS_MISS_RD: handler_offset = OFS_DTRANS_MISS_RD;
			PRIO_DTRANS_MISS_WR: handler_offset = OFS_DTRANS_MISS_WR;
			PRIO_DTRANS_PROT_RD: handler_offset = OFS_DTRANS_PROT_RD;
			PRIO_DTRANS_PROT_WR: handler_offset = OFS_DTRANS_PROT_WR;
			PRIO_DTRANS_MOD: handler_offset = OFS_DTRANS_MOD;
			default: handler_offset = OFS_UNRECOV;
		endcase
	endfunction : handler_offset

	// Source of the handler address for a slot
	function automatic vec_kind_type vec_kind(input logic [4:0] p);
		if (p == PRIO_DEBUG_STOP) begin
			vec_kind = VEC_DEBUG;
		end else if (p >= PRIO_IRQ3 && p <= PRIO_IRQ0) begin
			vec_kind = VEC_AUTO;
		end else begin
			vec_kind = VEC_FIXED;
		end
	endfunction : vec_kind

	// Source of the saved return address for a slot
	function automatic ret_kind_type ret_kind(input logic [4:0] p);
		case (p)
			PRIO_DEBUG_STOP, PRIO_BUS_DATA, PRIO_BUS_INSTR, PRIO_NMI,
			PRIO_BREAKPOINT: ret_kind = RET_NONCOMPLETE;
			PRIO_SVC: ret_kind = RET_SVC;
			default: begin
				if (p >= PRIO_IRQ3 && p <= PRIO_IRQ0) begin
					ret_kind = RET_NONCOMPLETE;
				end else begin
					ret_kind = RET_OFFEND;
				end
			end
		endcase
	endfunction : ret_kind

endpackage : exc_pkg

// *** rtl/prio_select.sv ***
// Lowest-index-wins selector over a vector of pending slots
module prio_select
	import exc_pkg::*;
#(
	parameter int N = NUM_SLOTS,
	parameter int IW = $clog2(N)
) (
	input wire logic [N-1:0] pend_in, // Pending slots
	output logic found_out, // Some slot pending
	output logic [IW-1:0] index_out // Lowest pending slot
);

	logic [N-1:0] below;
	logic [N-1:0] first;

	// Mark the single lowest set bit
	assign below[0] = 1'b0;
	assign first[0] = pend_in[0];
	generate
		for (genvar i = 1; i < N; i++) begin : g_chain
			assign below[i] = below[i-1] | pend_in[i-1];
			assign first[i] = pend_in[i] & ~below[i];
		end
	endgenerate

	// Encode the one-hot winner
	always_comb begin
		index_out = '0;
		for (int i = 0; i < N; i++) begin
			if (first[i]) begin
				index_out = IW'(i);
			end
		end
	end

	assign found_out = |pend_in;

endmodule : prio_select

// *** rtl/boot_sequencer.sv ***
// Reset hold, start-up clock setting and first fetch request
module boot_sequencer
	import exc_pkg::*;
(
	input wire logic clk_in, // Core clock
	input wire logic rst_in, // Sync reset, high
	input wire logic power_stable_in, // Power-on detector settled
	input wire logic io_supply_ok_in, // I/O supply above minimum
	input wire logic cfg_valid_in, // Clock setting write strobe
	input wire logic [1:0] cfg_src_in, // New clock source
	input wire logic cfg_pll_in, // New PLL enable
	input wire logic [DIV_W-1:0] cfg_div_in, // New divider
	output logic core_reset_out, // Core held in reset
	output logic fetch_start_out, // First fetch pulse
	output logic running_out, // Core running
	output logic [1:0] clk_src_out, // Selected clock source
	output logic pll_en_out, // PLL enable
	output logic [DIV_W-1:0] clk_div_out // Module clock divider
);

	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_FETCH = 3'b010,
		ST_RUN = 3'b100
	} boot_state_type;

	boot_state_type state_reg;
	boot_state_type state_next;
	logic hold;

	// Any reset source keeps the core held
	assign hold = rst_in | ~power_stable_in | ~io_supply_ok_in;

	// Sequence through hold, one fetch cycle, run
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_HOLD: state_next = ST_FETCH;
			ST_FETCH: state_next = ST_RUN;
			ST_RUN: state_next = ST_RUN;
			default: state_next = ST_HOLD;
		endcase
		if (hold) begin
			state_next = ST_HOLD;
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		state_reg <= state_next;
	end

	// Clock setting: RC, PLLs off, undivided until software changes it
	always_ff @(posedge clk_in) begin
		if (hold) begin
			clk_src_out <= CLK_SRC_RST;
			pll_en_out <= PLL_EN_RST;
			clk_div_out <= CLK_DIV_RST;
		end else if (cfg_valid_in && state_reg == ST_RUN) begin
			clk_src_out <= cfg_src_in;
			pll_en_out <= cfg_pll_in;
			clk_div_out <= cfg_div_in;
		end
	end

	assign core_reset_out = (state_reg == ST_HOLD);
	assign fetch_start_out = (state_reg == ST_FETCH);
	assign running_out = (state_reg == ST_RUN);

	// Loss of power holds the core next cycle
	power_hold_a: assert property (@(posedge clk_in)
		!power_stable_in |=> core_reset_out)
		else $error("core not held while power unsettled");

	// Low I/O supply holds the core next cycle
	io_hold_a: assert property (@(posedge clk_in)
		!io_supply_ok_in |=> core_reset_out && !fetch_start_out)
		else $error("core not held while io supply low");

	// Leaving reset gives one fetch cycle then running
	sequence s_release;
		$fell(core_reset_out);
	endsequence
	fetch_seq_a: assert property (@(posedge clk_in) disable iff (hold)
		s_release |-> fetch_start_out ##1 (running_out && !fetch_start_out))
		else $error("fetch sequence after release wrong");

	// Clock setting at release is the start-up one
	clk_start_a: assert property (@(posedge clk_in)
		$fell(core_reset_out) |->
		clk_src_out == CLK_SRC_RC && !pll_en_out && clk_div_out == CLK_DIV_RST)
		else $error("start-up clock setting wrong");

endmodule : boot_sequencer

// *** rtl/exception_priority_and_boot_vector.sv ***
// Event priority ranking, handler and return address, boot start
//
// Functional notes
// - Hold reset until power settles; run RC
// - Start-up: PLLs off, all clocks undivided
// - First fetch at start of flash
// - Low I/O supply keeps device in reset
// - Debug stop: priority 2, debugger-supplied handler
// - Unrecoverable: priority 3, offset 0x00
// - Multiple translation hit: priority 4, 0x04
// - Bus errors: data 5/0x08, instruction 6/0x0C
// - Non-maskable interrupt: priority 7, offset 0x10
// - Interrupt levels 3..0: priorities 8..11, autovectored
// - Instruction address: priority 12, offset 0x14
// - Instruction translation miss: priority 13, 0x50
// - Instruction translation protection: 14, 0x18
// - Breakpoint: priority 15, offset 0x1C
// - Decode faults 16..18 at 0x20..0x28
// - Floating-point and modified slots never raised
// - Coprocessor absent: priority 20, offset 0x30
// - Supervisor call: 21, 0x100, returns PC+2
// - Misaligned data read 22, write 23
// - Data translation misses: read 24, write 25
// - Data translation protection: read 26, write 27
// - Handler address is base OR offset
// - Autovector offset is fourteen bits wide
// - Higher class preempts ongoing lower class
module exception_priority_and_boot_vector
	import exc_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	input wire logic CLK_IN, // Core clock, 40 MHz
	input wire logic RST_IN, // Sync reset, high
	input wire logic POWER_STABLE_IN, // Power-on detector settled
	input wire logic IO_SUPPLY_OK_IN, // I/O brown-out detector ok
	input wire logic CLK_CFG_VALID_IN, // Clock setting strobe
	input wire logic [1:0] CLK_CFG_SRC_IN, // New clock source
	input wire logic CLK_CFG_PLL_IN, // New PLL enable
	input wire logic [DIV_W-1:0] CLK_CFG_DIV_IN, // New clock divider
	input wire logic [NUM_SLOTS-1:0] EVENT_IN, // Event levels by priority
	input wire logic [AW-1:0] VECTOR_BASE_IN, // Vector base address
	input wire logic [AW-1:0] DEBUG_HANDLER_IN, // Debugger handler address
	input wire logic [AUTOVEC_W-1:0] AUTOVECTOR_IN, // Interrupt offset
	input wire logic [AW-1:0] PC_OFFEND_IN, // PC of offending instr
	input wire logic [AW-1:0] PC_NONCOMPLETE_IN, // First non-completed
	input wire logic EVENT_RETURN_IN, // Handler finished pulse
	output logic CORE_RESET_OUT, // Core held in reset
	output logic FETCH_START_OUT, // First fetch pulse
	output logic [AW-1:0] FETCH_ADDR_OUT, // First fetch address
	output logic [1:0] CLK_SRC_OUT, // Selected clock source
	output logic PLL_EN_OUT, // PLL enable
	output logic [DIV_W-1:0] CLK_DIV_OUT, // Module clock divider
	output logic EVENT_TAKE_OUT, // Event taken pulse
	output logic [PRIO_W-1:0] EVENT_PRIO_OUT, // Taken priority
	output logic [AW-1:0] HANDLER_ADDR_OUT, // Handler target
	output logic [AW-1:0] RETURN_ADDR_OUT, // Address to save
	output logic [PRIO_W-1:0] ACTIVE_PRIO_OUT // Class now in handling
);

	logic running;
	logic [NUM_SLOTS-1:0] pend;
	logic [NUM_SLOTS-1:0] above_active;
	logic found;
	logic [PRIO_W-1:0] sel_prio;
	logic take;
	logic [AW-1:0] handler_next;
	logic [AW-1:0] return_next;
	logic [PRIO_W-1:0] active_reg;

	// Reset hold and start-up clocks
	boot_sequencer u_boot (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.power_stable_in(POWER_STABLE_IN),
		.io_supply_ok_in(IO_SUPPLY_OK_IN),
		.cfg_valid_in(CLK_CFG_VALID_IN),
		.cfg_src_in(CLK_CFG_SRC_IN),
		.cfg_pll_in(CLK_CFG_PLL_IN),
		.cfg_div_in(CLK_CFG_DIV_IN),
		.core_reset_out(CORE_RESET_OUT),
		.fetch_start_out(FETCH_START_OUT),
		.running_out(running),
		.clk_src_out(CLK_SRC_OUT),
		.pll_en_out(PLL_EN_OUT),
		.clk_div_out(CLK_DIV_OUT)
	);

	// Reset address is fixed
	assign FETCH_ADDR_OUT = RESET_ADDR;

	// Only classes more urgent than the one in handling compete
	generate
		for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_above
			assign above_active[i] = (PRIO_W'(i) < active_reg);
		end
	endgenerate

	// Unused and out-of-table slots are never raised
	assign pend = EVENT_IN & SLOT_VALID_MASK & above_active;

	prio_select #(
		.N(NUM_SLOTS),
		.IW(PRIO_W)
	) u_sel (
		.pend_in(pend),
		.found_out(found),
		.index_out(sel_prio)
	);

	assign take = running & found;

	// Handler address formed from the winning slot
	always_comb begin
		case (vec_kind(sel_prio))
			VEC_DEBUG: handler_next = DEBUG_HANDLER_IN;
			VEC_AUTO: handler_next = VECTOR_BASE_IN |
				{{(AW-AUTOVEC_W){1'b0}}, AUTOVECTOR_IN};
			default: handler_next = VECTOR_BASE_IN |
				AW'(handler_offset(sel_prio));
		endcase
	end

	// Return address chosen by slot kind
	always_comb begin
		case (ret_kind(sel_prio))
			RET_NONCOMPLETE: return_next = PC_NONCOMPLETE_IN;
			RET_SVC: return_next = PC_OFFEND_IN + AW'(SVC_RET_INC);
			default: return_next = PC_OFFEND_IN;
		endcase
	end

	// Register the taken event and its addresses
	always_ff @(posedge CLK_IN) begin
		if (CORE_RESET_OUT) begin
			EVENT_TAKE_OUT <= 1'b0;
			EVENT_PRIO_OUT <= PRIO_NONE;
			HANDLER_ADDR_OUT <= '0;
			RETURN_ADDR_OUT <= '0;
		end else begin
			EVENT_TAKE_OUT <= take;
			if (take) begin
				EVENT_PRIO_OUT <= sel_prio;
				HANDLER_ADDR_OUT <= handler_next;
				RETURN_ADDR_OUT <= return_next;
			end
		end
	end

	// Class in handling; a new take wins over a return
	always_ff @(posedge CLK_IN) begin
		if (CORE_RESET_OUT) begin
			active_reg <= PRIO_NONE;
		end else if (take) begin
			active_reg <= sel_prio;
		end else if (EVENT_RETURN_IN) begin
			active_reg <= PRIO_NONE;
		end
	end

	assign ACTIVE_PRIO_OUT = active_reg;

	// Taken slot had no more urgent eligible slot pending
	lowest_first_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		take |=> EVENT_TAKE_OUT &&
		(($past(pend) & ((32'h1 << EVENT_PRIO_OUT) - 32'h1)) == 32'h0))
		else $error("a more urgent pending event was skipped");

	// A take during handling is of a more urgent class
	preempt_only_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		take && active_reg != PRIO_NONE |=>
		EVENT_PRIO_OUT < $past(active_reg))
		else $error("event taken without preempting");

	// Unused slots never reach the core
	unused_slots_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		EVENT_TAKE_OUT |-> EVENT_PRIO_OUT != PRIO_FLOAT &&
		EVENT_PRIO_OUT != PRIO_DTRANS_MOD)
		else $error("unused slot taken");

	// Bus data error gets its fixed OR-formed handler
	sequence s_bus_data_take;
		take && sel_prio == PRIO_BUS_DATA;
	endsequence
	bus_vector_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		s_bus_data_take |=> HANDLER_ADDR_OUT ==
		($past(VECTOR_BASE_IN) | OFS_BUS_DATA) &&
		RETURN_ADDR_OUT == $past(PC_NONCOMPLETE_IN))
		else $error("bus data error vector wrong");

	// Supervisor call returns past itself
	svc_return_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		take && sel_prio == PRIO_SVC |=>
		RETURN_ADDR_OUT == $past(PC_OFFEND_IN) + 32'h2 &&
		HANDLER_ADDR_OUT == ($past(VECTOR_BASE_IN) | 32'h100))
		else $error("supervisor call addresses wrong");

	// Debug stop goes to the debugger's address
	debug_vector_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		take && sel_prio == PRIO_DEBUG_STOP |=>
		EVENT_PRIO_OUT == 5'h02 &&
		HANDLER_ADDR_OUT == $past(DEBUG_HANDLER_IN))
		else $error("debug stop handler wrong");

	// Interrupt levels use the autovector under the base
	irq_vector_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		take && sel_prio >= PRIO_IRQ3 && sel_prio <= PRIO_IRQ0 |=>
		HANDLER_ADDR_OUT == ($past(VECTOR_BASE_IN) |
		{18'h0, $past(AUTOVECTOR_IN)}))
		else $error("interrupt autovector wrong");

	// Illegal opcode saves the offending PC
	illegal_op_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		take && sel_prio == PRIO_ILLEGAL |=>
		RETURN_ADDR_OUT == $past(PC_OFFEND_IN) &&
		HANDLER_ADDR_OUT == ($past(VECTOR_BASE_IN) | 32'h20))
		else $error("illegal opcode addresses wrong");

	// Fixed slot: base OR offset, chosen saved address
	property p_fixed(prio, ofs, offend);
		@(posedge CLK_IN) disable iff (RST_IN)
		take && sel_prio == prio |=>
		EVENT_TAKE_OUT && EVENT_PRIO_OUT == prio &&
		HANDLER_ADDR_OUT == ($past(VECTOR_BASE_IN) | ofs) &&
		RETURN_ADDR_OUT == (offend ? $past(PC_OFFEND_IN) :
		$past(PC_NONCOMPLETE_IN));
	endproperty

	// Unrecoverable event
	unrecov_vec_a: assert property (
		p_fixed(PRIO_UNRECOV, OFS_UNRECOV, 1'b1))
		else $error("unrecoverable vector wrong");

	// Multiple translation hit
	multi_hit_a: assert property (
		p_fixed(PRIO_MULTI_HIT, OFS_MULTI_HIT, 1'b1))
		else $error("multiple hit vector wrong");

	// Instruction fetch bus error
	instr_bus_a: assert property (
		p_fixed(PRIO_BUS_INSTR, OFS_BUS_INSTR, 1'b0))
		else $error("fetch bus error vector wrong");

	// Non-maskable interrupt
	nmi_vector_a: assert property (
		p_fixed(PRIO_NMI, OFS_NMI, 1'b0))
		else $error("nmi vector wrong");

	// Instruction address fault
	instr_addr_a: assert property (
		p_fixed(PRIO_INSTR_ADDR, OFS_INSTR_ADDR, 1'b1))
		else $error("instruction address vector wrong");

	// Instruction translation miss
	instr_miss_a: assert property (
		p_fixed(PRIO_ITRANS_MISS, OFS_ITRANS_MISS, 1'b1))
		else $error("instruction miss vector wrong");

	// Instruction translation protection
	instr_prot_a: assert property (
		p_fixed(PRIO_ITRANS_PROT, OFS_ITRANS_PROT, 1'b1))
		else $error("instruction protection vector wrong");

	// Breakpoint
	breakpoint_vec_a: assert property (
		p_fixed(PRIO_BREAKPOINT, OFS_BREAKPOINT, 1'b0))
		else $error("breakpoint vector wrong");

	// Unimplemented instruction
	unimpl_vec_a: assert property (
		p_fixed(PRIO_UNIMPL, OFS_UNIMPL, 1'b1))
		else $error("unimplemented vector wrong");

	// Privilege violation
	priv_vec_a: assert property (
		p_fixed(PRIO_PRIV, OFS_PRIV, 1'b1))
		else $error("privilege vector wrong");

	// Coprocessor absent
	coproc_vec_a: assert property (
		p_fixed(PRIO_COPROC, OFS_COPROC, 1'b1))
		else $error("coprocessor vector wrong");

	// Misaligned data read
	daddr_rd_a: assert property (
		p_fixed(PRIO_DADDR_RD, OFS_DADDR_RD, 1'b1))
		else $error("data read address vector wrong");

	// Misaligned data write
	daddr_wr_a: assert property (
		p_fixed(PRIO_DADDR_WR, OFS_DADDR_WR, 1'b1))
		else $error("data write address vector wrong");

	// Data translation read miss
	dmiss_rd_a: assert property (
		p_fixed(PRIO_DTRANS_MISS_RD, OFS_DTRANS_MISS_RD, 1'b1))
		else $error("data read miss vector wrong");

	// Data translation write miss
	dmiss_wr_a: assert property (
		p_fixed(PRIO_DTRANS_MISS_WR, OFS_DTRANS_MISS_WR, 1'b1))
		else $error("data write miss vector wrong");

	// Data translation read protection
	dprot_rd_a: assert property (
		p_fixed(PRIO_DTRANS_PROT_RD, OFS_DTRANS_PROT_RD, 1'b1))
		else $error("data read protection vector wrong");

	// Data translation write protection
	dprot_wr_a: assert property (
		p_fixed(PRIO_DTRANS_PROT_WR, OFS_DTRANS_PROT_WR, 1'b1))
		else $error("data write protection vector wrong");

	// Interrupt levels save the first non-completed address
	irq_return_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		take && sel_prio >= PRIO_IRQ3 && sel_prio <= PRIO_IRQ0 |=>
		RETURN_ADDR_OUT == $past(PC_NONCOMPLETE_IN))
		else $error("interrupt return address wrong");

	// A return with no take frees the class
	return_free_a: assert property (@(posedge CLK_IN)
		disable iff (RST_IN)
		!take && EVENT_RETURN_IN |=>
		ACTIVE_PRIO_OUT == PRIO_NONE)
		else $error("return did not free the class");

	// No event is taken while the core is in reset
	no_take_reset_a: assert property (@(posedge CLK_IN)
		CORE_RESET_OUT |=> !EVENT_TAKE_OUT)
		else $error("event taken while in reset");

endmodule : exception_priority_and_boot_vector

// *** test/event_source_model.sv ***
// Far-side model: event sources and clock setting requester
module event_source_model
	import exc_pkg::*;
(
	input wire logic clk_in, // Core clock
	input wire logic rst_in, // Sync reset, high
	input wire logic [NUM_SLOTS-1:0] raise_in, // Sources to raise
	input wire logic [NUM_SLOTS-1:0] drop_in, // Sources to withdraw
	input wire logic take_in, // Event taken pulse
	input wire logic [PRIO_W-1:0] prio_in, // Taken priority
	input wire logic core_ok_in, // Core supply above minimum
	input wire logic cfg_req_in, // Software wants a new clock
	output logic [NUM_SLOTS-1:0] event_out, // Requests as levels
	output logic cfg_valid_out // Clock setting strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [NUM_SLOTS-1:0] served;

	// Slot that the unit has just taken
	assign served = take_in ? (32'h1 << prio_in) : '0;

	// Requests held as levels until taken or withdrawn
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			event_out <= '0;
		end else begin
			event_out <= (event_out | raise_in) & ~drop_in & ~served;
		end
	end

	// Fast clock only once the core supply is confirmed
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg_valid_out <= 1'b0;
		end else begin
			cfg_valid_out <= cfg_req_in & core_ok_in;
		end
	end
endmodule : event_source_model

// *** test/exception_priority_and_boot_vector_tb_top.sv ***
// Self-checking bench for the event priority and boot unit
module exception_priority_and_boot_vector_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import exc_pkg::*;
	logic clk, rst, pwr_ok, io_ok, cfg_pll, cfg_req, core_ok, ev_ret;
	logic cfg_valid, core_rst, fetch, pll_en, take, got;
	logic [1:0] cfg_src, clk_src;
	logic [DIV_W-1:0] cfg_div, clk_div;
	logic [NUM_SLOTS-1:0] raise, drop, ev;
	logic [ADDR_W-1:0] base, dbg, pc_off, pc_nc, fetch_addr, hnd, ret_a;
	logic [AUTOVEC_W-1:0] avec;
	logic [PRIO_W-1:0] prio, act;
	logic [31:0] seed, m;
	int errors, n_checks, p;
	// Handler offsets by slot, zero where not fixed
	logic [31:0] ofs_t [32] = '{
		32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h8, 32'hc, 32'h10,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h14, 32'h50, 32'h18, 32'h1c,
		32'h20, 32'h24, 32'h28, 32'h2c, 32'h30, 32'h100, 32'h34, 32'h38,
		32'h60, 32'h70, 32'h3c, 32'h40, 32'h44, 32'h0, 32'h0, 32'h0};

	exception_priority_and_boot_vector dut (.CLK_IN(clk), .RST_IN(rst),
		.POWER_STABLE_IN(pwr_ok), .IO_SUPPLY_OK_IN(io_ok),
		.CLK_CFG_VALID_IN(cfg_valid), .CLK_CFG_SRC_IN(cfg_src),
		.CLK_CFG_PLL_IN(cfg_pll), .CLK_CFG_DIV_IN(cfg_div), .EVENT_IN(ev),
		.VECTOR_BASE_IN(base), .DEBUG_HANDLER_IN(dbg), .AUTOVECTOR_IN(avec),
		.PC_OFFEND_IN(pc_off), .PC_NONCOMPLETE_IN(pc_nc),
		.EVENT_RETURN_IN(ev_ret), .CORE_RESET_OUT(core_rst),
		.FETCH_START_OUT(fetch), .FETCH_ADDR_OUT(fetch_addr),
		.CLK_SRC_OUT(clk_src), .PLL_EN_OUT(pll_en), .CLK_DIV_OUT(clk_div),
		.EVENT_TAKE_OUT(take), .EVENT_PRIO_OUT(prio),
		.HANDLER_ADDR_OUT(hnd), .RETURN_ADDR_OUT(ret_a),
		.ACTIVE_PRIO_OUT(act));

	event_source_model partner (.clk_in(clk), .rst_in(rst),
		.raise_in(raise), .drop_in(drop), .take_in(take), .prio_in(prio),
		.core_ok_in(core_ok), .cfg_req_in(cfg_req), .event_out(ev),
		.cfg_valid_out(cfg_valid));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Expected handler and saved address of a slot
	function automatic logic [31:0] exp_hnd(input int s);
		if (s == 2) return dbg;
		if (s >= 8 && s <= 11) return base | {18'h0, avec};
		return base | ofs_t[s];
	endfunction : exp_hnd
	function automatic logic [31:0] exp_ret(input int s);
		if (s == 21) return pc_off + 32'h2;
		if (((32'h0000_8fe4 >> s) & 32'h1) != 32'h0) return pc_nc;
		return pc_off;
	endfunction : exp_ret

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	// Raise sources with fresh random context
	task automatic fire(input logic [31:0] mask);
		logic [31:0] r;
		r = xs();
		@(posedge clk);
		raise <= mask;
		base <= xs();
		dbg <= xs();
		pc_off <= xs();
		pc_nc <= xs();
		avec <= r[AUTOVEC_W-1:0];
		@(posedge clk);
		raise <= '0;
	endtask : fire

	task automatic wait_take();
		got = 1'b0;
		for (int i = 0; i < 8 && !got; i++) begin
			@(posedge clk);
			#1;
			got = (take === 1'b1);
		end
	endtask : wait_take

	task automatic expect_take(input int s);
		wait_take();
		chk("take", 32'(got), 32'h1);
		chk("prio", 32'(prio), s);
		chk("handler", hnd, exp_hnd(s));
		chk("return", ret_a, exp_ret(s));
		chk("active", 32'(act), s);
	endtask : expect_take

	task automatic give_back();
		@(posedge clk);
		ev_ret <= 1'b1;
		@(posedge clk);
		ev_ret <= 1'b0;
		#1;
		chk("active idle", 32'(act), 32'h1f);
	endtask : give_back

	// Hold by one cause, then release and watch the first fetch
	task automatic boot(input int k);
		@(posedge clk);
		if (k == 0) rst <= 1'b1;
		if (k == 1) pwr_ok <= 1'b0;
		if (k == 2) io_ok <= 1'b0;
		cfg_req <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("held", 32'(core_rst), 32'h1);
		chk("source", 32'(clk_src), 32'h0);
		chk("pll", 32'(pll_en), 32'h0);
		chk("divider", 32'(clk_div), 32'h0);
		@(posedge clk);
		rst <= 1'b0;
		pwr_ok <= 1'b1;
		io_ok <= 1'b1;
		cfg_req <= 1'b0;
		@(posedge clk);
		#1;
		chk("released", 32'(core_rst), 32'h0);
		chk("fetch", 32'(fetch), 32'h1);
		chk("fetch addr", fetch_addr, 32'h8000_0000);
		@(posedge clk);
		#1;
		chk("fetch end", 32'(fetch), 32'h0);
		chk("kept", 32'(clk_src), 32'h0);
	endtask : boot

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_of_test();
	end

	initial begin
		{rst, pwr_ok, io_ok} = 3'h7;
		{cfg_pll, cfg_req, core_ok, ev_ret} = 4'h0;
		{cfg_src, cfg_div, raise, drop} = '0;
		{base, dbg, pc_off, pc_nc, avec} = '0;
		seed = 32'd97;
		repeat (16) @(posedge clk);
		boot(0);
		// Switch clock after the supply check
		@(posedge clk);
		{cfg_src, cfg_pll, cfg_div} <= 7'h5b;
		{core_ok, cfg_req} <= 2'h3;
		@(posedge clk);
		cfg_req <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("new clock", {25'h0, clk_src, pll_en, clk_div}, 32'h5b);
		boot(2);
		boot(1);
		// Every raisable slot alone, 2..27 without 19
		for (int s = 2; s < 28; s++) begin
			if (s != 19) begin
				fire(32'h1 << s);
				expect_take(s);
				give_back();
			end
		end
		// Unused slots never answer
		fire(32'h1008_0003);
		wait_take();
		chk("unused", 32'(got), 32'h0);
		@(posedge clk);
		drop <= 32'h1008_0003;
		@(posedge clk);
		drop <= '0;
		// Preemption, then refusal of a lower class
		fire(32'h1 << 20);
		expect_take(20);
		fire(32'h1 << 5);
		expect_take(5);
		fire(32'h1 << 22);
		wait_take();
		chk("refused", 32'(got), 32'h0);
		give_back();
		expect_take(22);
		give_back();
		// Random sets pending together
		repeat (12) begin
			m = xs() & SLOT_VALID_MASK;
			if (m == 32'h0) m = 32'h4;
			fire(m);
			while (m != 32'h0) begin
				for (p = 0; !m[p]; p++) begin
				end
				expect_take(p);
				m[p] = 1'b0;
				give_back();
			end
		end
		end_of_test();
	end
endmodule : exception_priority_and_boot_vector_tb_top
